// *** dv/acmp_cells_model.sv ***
// Behavioural comparator cells facing the control block.
// Assumes the bench sets each channel's analog relation.
`timescale 1ns/100ps
`default_nettype none
module acmp_cells_model #(parameter int NCH = 6) (
  input  wire logic [NCH-1:0][3:0] in_sel,
  input  wire logic [NCH-1:0][3:0] ref_sel,
  input  wire logic [NCH-1:0]      enable,
  input  wire logic [NCH-1:0]      above,
  output logic      [NCH-1:0]      cmp_out
);
  // Open switches or a stopped cell give a low result
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      cmp_out[i] = enable[i] & (|in_sel[i]) & (|ref_sel[i]) & above[i];
  end
endmodule : acmp_cells_model
`default_nettype wire

// *** dv/acmp_ctrl_bench.sv ***
// Bench: register rows, then path, edge, filter and stop cases.
// Assumes the cells model and the monitor are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_ctrl_bench;
  localparam int NCH = 6;
  localparam int FILT_N = 3;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} acmp_row_t;
  logic                              sys_clk = 1'b0;
  logic                              nrst = 1'b0;
  acmp_pkg::acmp_bus_req_t           bus_req = '0;
  logic [31:0]                       bus_rdata;
  logic [NCH-1:0]                    cmp_raw, cmp_enable, comparator_output_pin, comparator_output_pin_oe;
  logic [NCH-1:0]                    event_linking_logic, output_protect_level;
  logic [NCH-1:0]                    above = '0;
  logic [NCH-1:0][3:0]               input_select_field, reference_select_field;
  acmp_pkg::acmp_protect_t [NCH-1:0] output_protect_timer;
  logic                              irq;
  int                                miscompares = 0;
  int                                check_count = 0;
  int                                n;
  int                                d [3] = '{1, `ACMP_MID_DIV, `ACMP_SLOW_DIV};
  acmp_row_t rows [10] = '{'{8'h00, 32'h1, 32'h1}, '{8'h04, 32'h2, 32'h2}, '{8'h08, 32'h4, 32'h4},
    '{8'h0C, 32'h8, 32'h8}, '{8'h20, 32'h1, 32'h1}, '{8'h24, 32'h2, 32'h2}, '{8'h28, 32'h4, 32'h4},
    '{8'h2C, 32'h8, 32'h8}, '{8'h6C, 32'h3F, 32'h3F}, '{8'h80, 32'hFF, 32'h0}};
  always #50 sys_clk = ~sys_clk;
  acmp_ctrl #(.NCH(NCH), .FILT_N(FILT_N)) i_acmp_ctrl (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .cmp_raw(cmp_raw), .input_select_field(input_select_field),
    .reference_select_field(reference_select_field), .cmp_enable(cmp_enable),
    .comparator_output_pin(comparator_output_pin), .comparator_output_pin_oe(comparator_output_pin_oe),
    .event_linking_logic(event_linking_logic), .output_protect_level(output_protect_level),
    .output_protect_timer(output_protect_timer), .irq(irq));
  acmp_cells_model #(.NCH(NCH)) i_acmp_cells_model (.in_sel(input_select_field),
    .ref_sel(reference_select_field), .enable(cmp_enable), .above(above), .cmp_out(cmp_raw));
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    bus_req <= '{1'b1, 1'b0, a, w};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 chk(nm, bus_rdata, e);
  endtask : rd_chk
  // Bounded so a dead filter ends the run instead of hanging it
  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    while (output_protect_level[0] !== v && c < 300)
    begin
      @(posedge sys_clk);
      #1 c++;
    end
    if (c == 300)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask : wait_lvl
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(`ACMP_STOP_OFS, 32'h1, "stop");
    chk("enable", cmp_enable, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e, "row");
    end
    wr(`ACMP_STOP_OFS, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      chk("in", input_select_field[i], 32'h1 << i);
      chk("ref", reference_select_field[i], 32'h1 << i);
    end
    wr(8'h10, 32'h3);
    wr(8'h30, 32'hF);
    chk("bad", {input_select_field[4], reference_select_field[4]}, 32'h0);
    wr(`ACMP_CTL_BASE, 32'h28);
    @(posedge sys_clk);
    above[0] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("lvl", output_protect_level[0], 32'h0);
    @(posedge sys_clk);
    #1 chk("lvl", output_protect_level[0], 32'h1);
    chk("pin", comparator_output_pin[0] & comparator_output_pin_oe[0], 32'h1);
    chk("evt", {event_linking_logic[0], output_protect_timer[0].edge_pulse}, 32'h3);
    @(posedge sys_clk);
    #1 chk("irq", irq, 32'h1);
    chk("evt end", {event_linking_logic[0], output_protect_timer[0].edge_pulse}, 32'h0);
    rd_chk(`ACMP_RES_OFS, 32'h1, "res");
    wr(`ACMP_MASK_OFS, 32'h0);
    chk("mask", irq, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(`ACMP_STAT_OFS, 32'h1);
      wr(`ACMP_CTL_BASE, k == 0 ? 32'h28 : (k == 3 ? 32'h38 : 32'h30));
      @(posedge sys_clk);
      above[0] <= ~above[0];
      repeat (6) @(posedge sys_clk);
      rd_chk(`ACMP_STAT_OFS, {31'h0, k >= 2}, "stat");
    end
    for (int p = 0; p < 3; p++)
    begin
      wr(`ACMP_CTL_BASE, 32'h29 | (p << 1));
      @(posedge sys_clk);
      above[0] <= ~above[0];
      wait_lvl(~above[0], n);
      chk("flt", n >= (FILT_N - 1) * d[p] + 2 && n <= FILT_N * d[p] + 6, 32'h1);
    end
    wr(`ACMP_CTL_BASE, 32'h29);
    @(posedge sys_clk);
    above[0] <= ~above[0];
    @(posedge sys_clk);
    above[0] <= ~above[0];
    // An unfiltered path would show the pulse exactly here
    repeat (2) @(posedge sys_clk);
    #1 chk("glitch", output_protect_level[0], above[0]);
    repeat (10) @(posedge sys_clk);
    #1 chk("glitch", output_protect_level[0], above[0]);
    wr(`ACMP_STOP_OFS, 32'h1);
    chk("halt", {cmp_enable, comparator_output_pin_oe, input_select_field[0]}, 32'h0);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(`ACMP_STAT_OFS, 32'h0, "rst stat");
    rd_chk(`ACMP_CTL_BASE, 32'h0, "rst ctl");
    chk("rst irq", irq, 32'h0);
    report_and_stop;
  end
endmodule : acmp_ctrl_bench
bind acmp_ctrl acmp_ctrl_monitor #(.NCH(NCH), .FILT_N(FILT_N)) u_acmp_mon (.sys_clk(sys_clk), .nrst(nrst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .cmp_raw(cmp_raw), .input_select_field(input_select_field),
  .reference_select_field(reference_select_field), .cmp_enable(cmp_enable),
  .comparator_output_pin(comparator_output_pin), .comparator_output_pin_oe(comparator_output_pin_oe),
  .event_linking_logic(event_linking_logic), .output_protect_level(output_protect_level),
  .output_protect_timer(output_protect_timer), .irq(irq));
`default_nettype wire

// *** dv/acmp_ctrl_monitor.sv ***
// Checker on the comparator control ports, channel 0 for timing.
// Assumes a bind into acmp_ctrl.
`timescale 1ns/100ps
`default_nettype none
module acmp_ctrl_monitor #(parameter int NCH = 6, parameter int FILT_N = 3) (
  input wire logic                              sys_clk,
  input wire logic                              nrst,
  input wire acmp_pkg::acmp_bus_req_t           bus_req,
  input wire logic [31:0]                       bus_rdata,
  input wire logic [NCH-1:0]                    cmp_raw,
  input wire logic [NCH-1:0][3:0]               input_select_field,
  input wire logic [NCH-1:0][3:0]               reference_select_field,
  input wire logic [NCH-1:0]                    cmp_enable,
  input wire logic [NCH-1:0]                    comparator_output_pin,
  input wire logic [NCH-1:0]                    comparator_output_pin_oe,
  input wire logic [NCH-1:0]                    event_linking_logic,
  input wire logic [NCH-1:0]                    output_protect_level,
  input wire acmp_pkg::acmp_protect_t [NCH-1:0] output_protect_timer,
  input wire logic                              irq
);
  logic sel_ok;
  always_comb
  begin
    sel_ok = 1'b1;
    for (int i = 0; i < NCH; i++)
      sel_ok = sel_ok & $onehot0(input_select_field[i]) & $onehot0(reference_select_field[i]);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_lvl_moved;
    output_protect_level[0] != $past(output_protect_level[0]);
  endsequence
  a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == '0) else $error("stray rdata");
  a_select_one_hot: assert property (sel_ok) else $error("select not one-hot");
  a_stop_opens_sel: assert property (!cmp_enable[0] |-> input_select_field[0] == 4'h0) else $error("stop sel");
  a_pin_needs_level: assert property (comparator_output_pin[0] |-> output_protect_level[0]) else $error("pin");
  a_timer_level_same: assert property (output_protect_timer[0].level == output_protect_level[0])
    else $error("timer level");
  a_edge_after_move: assert property (output_protect_timer[0].edge_pulse |-> s_lvl_moved) else $error("edge");
  a_event_on_edge: assert property (event_linking_logic[0] |-> output_protect_timer[0].edge_pulse)
    else $error("event");
  a_level_synced: assert property ($changed(output_protect_level[0]) |-> output_protect_level[0] == $past(cmp_raw[0], 3))
    else $error("level");
endmodule : acmp_ctrl_monitor
`default_nettype wire

// *** verilog/acmp_ctrl.sv ***
// Control logic around a bank of analog comparators: selection, noise filter, edges, interrupt, register port.
// Assumes comparator outputs are asynchronous; register port strobes are one-cycle and synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "acmp_defs.svh"
module acmp_ctrl #(
  parameter int NCH    = 6,
  parameter int FILT_N = 3
) (
  input  wire logic                            sys_clk,
  input  wire logic                            nrst,
  input  wire acmp_pkg::acmp_bus_req_t         bus_req,
  output logic [`ACMP_DATA_W-1:0]              bus_rdata,
  input  wire logic [NCH-1:0]                  cmp_raw,
  output logic [NCH-1:0][3:0]                  input_select_field,
  output logic [NCH-1:0][3:0]                  reference_select_field,
  output logic [NCH-1:0]                       cmp_enable,
  output logic [NCH-1:0]                       comparator_output_pin,
  output logic [NCH-1:0]                       comparator_output_pin_oe,
  output logic [NCH-1:0]                       event_linking_logic,
  output logic [NCH-1:0]                       output_protect_level,
  output acmp_pkg::acmp_protect_t [NCH-1:0]    output_protect_timer,
  output logic                                 irq
);

  // Mask and status share one byte; the history needs two samples at least
  if (NCH < 1 || NCH > 8)
  begin : g_bad_nch
    $error("acmp_ctrl: NCH must be 1 to 8");
  end
  if (FILT_N < 2 || FILT_N > 8)
  begin : g_bad_filt
    $error("acmp_ctrl: FILT_N must be 2 to 8");
  end

  function automatic logic [`ACMP_ADDR_W-1:0] reg_ofs(input logic [`ACMP_ADDR_W-1:0] base, input int idx);
    reg_ofs = base + `ACMP_ADDR_W'(idx * 4);
  endfunction : reg_ofs

  // Zero or one bit set; anything else is treated as no connection
  function automatic logic sel_legal(input logic [3:0] sel);
    sel_legal = (sel & (sel - 4'h1)) == 4'h0;
  endfunction : sel_legal

  logic [NCH-1:0][3:0]            in_sel_reg;
  logic [NCH-1:0][3:0]            in_sel_next;
  logic [NCH-1:0][3:0]            ref_sel_reg;
  logic [NCH-1:0][3:0]            ref_sel_next;
  acmp_pkg::acmp_ctl_t [NCH-1:0]  ctl_reg;
  acmp_pkg::acmp_ctl_t [NCH-1:0]  ctl_next;
  logic                           stop_reg;
  logic                           stop_next;
  logic [NCH-1:0]                 stat_reg;
  logic [NCH-1:0]                 stat_next;
  logic [NCH-1:0]                 mask_reg;
  logic [NCH-1:0]                 mask_next;
  logic [`ACMP_DATA_W-1:0]        rdata_reg;
  logic [`ACMP_DATA_W-1:0]        rdata_next;
  logic [`ACMP_PRESC_W-1:0]       presc_reg;
  logic [`ACMP_PRESC_W-1:0]       presc_next;
  logic [NCH-1:0]                 filt_w;
  logic [NCH-1:0]                 rise_w;
  logic [NCH-1:0]                 fall_w;
  logic [NCH-1:0]                 vedge;
  logic                           tick_mid;
  logic                           tick_slow;

  // Shared prescaler for the sampling periods; frozen during module stop
  always_comb
  begin
    presc_next = stop_reg ? presc_reg : presc_reg + `ACMP_PRESC_W'(1);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      presc_reg <= '0;
    else
      presc_reg <= presc_next;
  end

  assign tick_mid  = presc_reg[2:0] == 3'(`ACMP_MID_DIV - 1);
  assign tick_slow = presc_reg == `ACMP_PRESC_W'(`ACMP_SLOW_DIV - 1);

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic [1:0]        sync_reg;
      logic [1:0]        sync_next;
      logic [FILT_N-1:0] hist_reg;
      logic [FILT_N-1:0] hist_next;
      logic              filt_reg;
      logic              filt_next;
      logic              rise_reg;
      logic              rise_next;
      logic              fall_reg;
      logic              fall_next;
      logic              tick;

      always_comb
      begin
        case (ctl_reg[g].period)
          `ACMP_PER_FAST: tick = 1'b1;
          `ACMP_PER_MID:  tick = tick_mid;
          `ACMP_PER_SLOW: tick = tick_slow;
          default:        tick = tick_slow;
        endcase
      end

      // Synchroniser: only the second stage is read downstream
      always_comb
      begin
        sync_next = sync_reg;
        if (!stop_reg)
          sync_next = {sync_reg[0], cmp_raw[g]};
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          sync_reg <= '0;
        else
          sync_reg <= sync_next;
      end

      // Noise filter: sample history and the level it settles on
      always_comb
      begin
        hist_next = hist_reg;
        filt_next = filt_reg;
        if (!stop_reg)
        begin
          if (tick)
            hist_next = {hist_reg[FILT_N-2:0], sync_reg[1]};
          if (!ctl_reg[g].filt_en)
            filt_next = sync_reg[1];
          else if (hist_next == {FILT_N{hist_next[0]}})
            filt_next = hist_next[0];
        end
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          hist_reg <= '0;
          filt_reg <= 1'b0;
        end
        else
        begin
          hist_reg <= hist_next;
          filt_reg <= filt_next;
        end
      end

      // Edges come from the filtered level so every consumer sees one history
      always_comb
      begin
        rise_next = filt_next & ~filt_reg;
        fall_next = ~filt_next & filt_reg;
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          rise_reg <= 1'b0;
          fall_reg <= 1'b0;
        end
        else
        begin
          rise_reg <= rise_next;
          fall_reg <= fall_next;
        end
      end

      assign filt_w[g] = filt_reg;
      assign rise_w[g] = rise_reg;
      assign fall_w[g] = fall_reg;
      assign vedge[g]  = (rise_reg & ctl_reg[g].edge_sel[0]) | (fall_reg & ctl_reg[g].edge_sel[1]);

      // Illegal codes open every switch rather than shorting two pins together
      assign input_select_field[g]     = (sel_legal(in_sel_reg[g]) && !stop_reg) ? in_sel_reg[g] : 4'h0;
      assign reference_select_field[g] = (sel_legal(ref_sel_reg[g]) && !stop_reg) ? ref_sel_reg[g] : 4'h0;
      assign cmp_enable[g]               = !stop_reg;
      assign comparator_output_pin[g]    = filt_reg & ctl_reg[g].pin_en;
      assign comparator_output_pin_oe[g] = ctl_reg[g].pin_en & !stop_reg;
      assign event_linking_logic[g]      = vedge[g];
      assign output_protect_level[g]     = filt_reg;
      assign output_protect_timer[g]     = '{level: filt_reg, edge_pulse: rise_reg | fall_reg};
    end
  endgenerate

  // Channel configuration registers
  always_comb
  begin
    in_sel_next  = in_sel_reg;
    ref_sel_next = ref_sel_reg;
    ctl_next     = ctl_reg;
    if (bus_req.wr)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (bus_req.addr == reg_ofs(`ACMP_IN_BASE, i))
          in_sel_next[i] = bus_req.wdata[3:0];
        if (bus_req.addr == reg_ofs(`ACMP_REF_BASE, i))
          ref_sel_next[i] = bus_req.wdata[3:0];
        if (bus_req.addr == reg_ofs(`ACMP_CTL_BASE, i))
          ctl_next[i] = bus_req.wdata[`ACMP_CTL_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_sel_reg  <= {NCH{`ACMP_SEL_RST}};
      ref_sel_reg <= {NCH{`ACMP_SEL_RST}};
      ctl_reg     <= {NCH{`ACMP_CTL_RST}};
    end
    else
    begin
      in_sel_reg  <= in_sel_next;
      ref_sel_reg <= ref_sel_next;
      ctl_reg     <= ctl_next;
    end
  end

  // Module stop and interrupt mask
  always_comb
  begin
    stop_next = stop_reg;
    mask_next = mask_reg;
    if (bus_req.wr && bus_req.addr == `ACMP_STOP_OFS)
      stop_next = bus_req.wdata[0];
    if (bus_req.wr && bus_req.addr == `ACMP_MASK_OFS)
      mask_next = bus_req.wdata[NCH-1:0];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_reg <= `ACMP_STOP_RST;
      mask_reg <= NCH'(`ACMP_MASK_RST);
    end
    else
    begin
      stop_reg <= stop_next;
      mask_reg <= mask_next;
    end
  end

  // Sticky status: a new edge in the clearing cycle survives the clear
  always_comb
  begin
    stat_next = stat_reg;
    if (bus_req.wr && bus_req.addr == `ACMP_STAT_OFS)
      stat_next = stat_reg & ~bus_req.wdata[NCH-1:0];
    stat_next = stat_next | vedge;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      stat_reg <= '0;
    else
      stat_reg <= stat_next;
  end

  // Read data stand one cycle after the strobe and are zero otherwise
  always_comb
  begin
    rdata_next = '0;
    if (bus_req.rd)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (bus_req.addr == reg_ofs(`ACMP_IN_BASE, i))
          rdata_next = `ACMP_DATA_W'(in_sel_reg[i]);
        if (bus_req.addr == reg_ofs(`ACMP_REF_BASE, i))
          rdata_next = `ACMP_DATA_W'(ref_sel_reg[i]);
        if (bus_req.addr == reg_ofs(`ACMP_CTL_BASE, i))
          rdata_next = `ACMP_DATA_W'(ctl_reg[i]);
      end
      case (bus_req.addr)
        `ACMP_STOP_OFS: rdata_next = `ACMP_DATA_W'(stop_reg);
        `ACMP_RES_OFS:  rdata_next = `ACMP_DATA_W'(filt_w);
        `ACMP_STAT_OFS: rdata_next = `ACMP_DATA_W'(stat_reg);
        `ACMP_MASK_OFS: rdata_next = `ACMP_DATA_W'(mask_reg);
        default:        rdata_next = rdata_next;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign bus_rdata = rdata_reg;
  assign irq       = |(stat_reg & mask_reg);

endmodule : acmp_ctrl
`default_nettype wire

// *** verilog/acmp_defs.svh ***
// Constants for the analog comparator control block: offsets, field codes, reset values, sampling counts.
// Assumes byte addresses on an 8-bit register port with 32-bit data, one word per register.
// Function
// - Six independent comparator channels, numbered zero-five
// - Four-bit per-channel input selection from four pins
// - Input select one-hot; zero connects nothing
// - One-hot reference select: converters, reference pins
// - Comparison result can drive an external pin
// - Filter samples at one of three periods
// - Filter bypass passes raw result downstream
// - Filtered result feeds irq, event, protect, status
// - Valid result edge raises interrupt request
// - Valid edge: rising, falling or both
// - Level to first protect; level+edge to second
// - Module stop halts logic until software releases
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

`define ACMP_ADDR_W      8
`define ACMP_DATA_W      32
`define ACMP_IN_BASE     8'h00
`define ACMP_REF_BASE    8'h20
`define ACMP_CTL_BASE    8'h40
`define ACMP_STOP_OFS    8'h60
`define ACMP_RES_OFS     8'h64
`define ACMP_STAT_OFS    8'h68
`define ACMP_MASK_OFS    8'h6C

`define ACMP_SEL_RST     4'h0
`define ACMP_CTL_RST     6'h00
`define ACMP_STOP_RST    1'b1
`define ACMP_MASK_RST    8'h00

`define ACMP_CTL_W       6
`define ACMP_PER_FAST    2'h0
`define ACMP_PER_MID     2'h1
`define ACMP_PER_SLOW    2'h2

`define ACMP_PRESC_W     5
`define ACMP_MID_DIV     8
`define ACMP_SLOW_DIV    32

`endif

// *** verilog/acmp_pkg.sv ***
// Types of the analog comparator control block.
// Assumes acmp_defs.svh is on the include path.
`default_nettype none
`include "acmp_defs.svh"
package acmp_pkg;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`ACMP_ADDR_W-1:0]   addr;
    logic [`ACMP_DATA_W-1:0]   wdata;
  } acmp_bus_req_t;

  typedef struct packed {
    logic       pin_en;
    logic [1:0] edge_sel;
    logic [1:0] period;
    logic       filt_en;
  } acmp_ctl_t;

  typedef struct packed {
    logic level;
    logic edge_pulse;
  } acmp_protect_t;

endpackage : acmp_pkg
`default_nettype wire
